// ==== design/pnvm_mem.sv ====
// Data EEPROM byte array with registered read data
`timescale 1ns/1ps
`default_nettype none
module pnvm_mem #(
    parameter int AW = 7
)
(
    input wire logic sys_clk,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge sys_clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : pnvm_mem
`default_nettype wire

// ==== design/pnvm_pkg.sv ====
// Package of constants for the parallel nonvolatile programming block
package pnvm_pkg;
    localparam logic [7:0] CMD_EE_WRITE = 8'h11;
    localparam logic [7:0] CMD_EE_READ = 8'h03;
    localparam logic [7:0] CMD_FUSE_WRITE = 8'h40;
    localparam logic [7:0] CMD_LOCK_WRITE = 8'h20;
    localparam logic [7:0] CMD_FUSE_READ = 8'h04;
    localparam logic [7:0] CMD_NONE = 8'h00;
    localparam logic [7:0] BYTE_ERASED = 8'hFF;
    localparam logic [5:0] FUSE_RESET = 6'h3F;
    localparam logic [1:0] LOCK_RESET = 2'h3;
    localparam int FUSE_SERIAL_BIT = 5;
    localparam int FUSE_BO_LEVEL_BIT = 4;
    localparam int FUSE_BO_DETECT_BIT = 3;
    localparam int FUSE_CLK_HI_BIT = 2;
    localparam int FUSE_HI_BIT = 5;
    localparam logic [1:0] FUSE_RSVD = 2'h3;
    localparam int CTRL_OE_BIT = 12;
    localparam int CTRL_BSEL_BIT = 11;
    localparam int CTRL_OP_HI = 10;
    localparam int CTRL_OP_LO = 8;
    localparam logic [7:0] BUS_IDLE = 8'h00;
    localparam int LOCK_LO_BIT = 1;
    localparam int LOCK_HI_BIT = 2;
    localparam logic [2:0] LOAD_CMD = 3'h1;
    localparam logic [2:0] LOAD_ADDR = 3'h2;
    localparam logic [2:0] LOAD_DATA = 3'h3;
    localparam logic [2:0] WRITE_STEP = 3'h4;
    localparam logic [2:0] CHIP_ERASE = 3'h5;
    localparam logic [31:0] WB_ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] WB_ADDR_STAT = 32'h0000_0004;
    localparam logic [31:0] WB_ADDR_FUSE = 32'h0000_0008;
endpackage : pnvm_pkg

// ==== design/pnvm_top.sv ====
// Parallel programming command handler for EEPROM, fuses and lock bits
// Summary of operation
// - Command 11h, address, data, then write step stores the EEPROM byte.
// - After command 03h, the addressed EEPROM byte is driven while output enable and byte select low.
// - Command 40h with data byte: zero programs a fuse, one erases it.
// - Fuse bits: 5 serial enable, 4 threshold, 3 detect enable, 2..0 clock.
// - Fuse programming never shows busy on the ready/busy indicator.
// - Command 20h, data bits 2 and 1 zero program the lock bits.
// - Lock bits only return unprogrammed through chip erase or reset.
// - Status read drives the fuses with bits 7..6 at one, zero meaning programmed.
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pnvm_top #(
    parameter int AW = 7
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [7:0] data_o,
    output logic data_oe_n,
    output logic ready_busy_indicator,
    output logic serial_program_enable_fuse,
    output logic brownout_threshold_fuse,
    output logic brownout_detect_enable_fuse,
    output logic [2:0] clock_source_select_fuse
);
    logic [7:0] cmd_r;
    logic [AW-1:0] addr_r;
    logic [7:0] data_r;
    logic [5:0] fuse_r;
    logic [1:0] lock_r;
    logic oe_n_r;
    logic bsel_r;
    logic ack_r;
    logic [31:0] rdat_r;
    logic [7:0] ee_rdata;
    logic ee_we;
    logic wr_req;
    logic [2:0] op;
    logic [7:0] opnd;

    ////////////////////////////////////////////////////////////////////////
    // Wishbone decode: CTRL write = {oe_n,byte_select,op[2:0],operand[7:0]}
    assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && ack_r
        && wb_adr_i == pnvm_pkg::WB_ADDR_CTRL && wb_sel_i[0];
    assign op = wr_req ? wb_dat_i[pnvm_pkg::CTRL_OP_HI:pnvm_pkg::CTRL_OP_LO] : 3'h0;
    assign opnd = wb_dat_i[7:0];
    assign ee_we = wr_req && op == pnvm_pkg::WRITE_STEP
        && cmd_r == pnvm_pkg::CMD_EE_WRITE;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdat_r <= 32'h0000_0000;
        end
        else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r)
        begin
            case (wb_adr_i)
                pnvm_pkg::WB_ADDR_CTRL: rdat_r <= {19'h0, oe_n_r, bsel_r, 3'h0, cmd_r};
                pnvm_pkg::WB_ADDR_STAT: rdat_r <= {24'h0, data_r};
                pnvm_pkg::WB_ADDR_FUSE: rdat_r <= {22'h0, lock_r, pnvm_pkg::FUSE_RSVD, fuse_r};
                default: rdat_r <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_dat_o = rdat_r;
    assign wb_ack_o = ack_r;

    ////////////////////////////////////////////////////////////////////////
    // Command, address and data latches
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cmd_r <= pnvm_pkg::CMD_NONE;
            addr_r <= '0;
            data_r <= pnvm_pkg::BYTE_ERASED;
            oe_n_r <= 1'b1;
            bsel_r <= 1'b0;
        end
        else if (wr_req)
        begin
            oe_n_r <= wb_dat_i[pnvm_pkg::CTRL_OE_BIT];
            bsel_r <= wb_dat_i[pnvm_pkg::CTRL_BSEL_BIT];
            case (op)
                pnvm_pkg::LOAD_CMD: cmd_r <= opnd;
                pnvm_pkg::LOAD_ADDR: addr_r <= opnd[AW-1:0];
                pnvm_pkg::LOAD_DATA: data_r <= opnd;
                default: cmd_r <= cmd_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fuse and lock storage
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fuse_r <= pnvm_pkg::FUSE_RESET;
        end
        else if (op == pnvm_pkg::WRITE_STEP && cmd_r == pnvm_pkg::CMD_FUSE_WRITE)
        begin
            fuse_r <= data_r[pnvm_pkg::FUSE_HI_BIT:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lock_r <= pnvm_pkg::LOCK_RESET;
        end
        else if (op == pnvm_pkg::CHIP_ERASE)
        begin
            lock_r <= pnvm_pkg::LOCK_RESET;
        end
        else if (op == pnvm_pkg::WRITE_STEP && cmd_r == pnvm_pkg::CMD_LOCK_WRITE)
        begin
            lock_r <= lock_r & data_r[pnvm_pkg::LOCK_HI_BIT:pnvm_pkg::LOCK_LO_BIT];
        end
    end

    pnvm_mem #(.AW(AW)) u_mem (
        .sys_clk(sys_clk),
        .we(ee_we),
        .addr(addr_r),
        .wdata(data_r),
        .rdata(ee_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Data bus and status outputs
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            data_o <= pnvm_pkg::BUS_IDLE;
            data_oe_n <= 1'b1;
        end
        else
        begin
            data_oe_n <= 1'b1;
            data_o <= pnvm_pkg::BUS_IDLE;
            if (!oe_n_r && !bsel_r)
            begin
                if (cmd_r == pnvm_pkg::CMD_EE_READ)
                begin
                    data_o <= ee_rdata;
                    data_oe_n <= 1'b0;
                end
                else if (cmd_r == pnvm_pkg::CMD_FUSE_READ)
                begin
                    data_o <= {pnvm_pkg::FUSE_RSVD, fuse_r};
                    data_oe_n <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ready_busy_indicator <= 1'b1;
            serial_program_enable_fuse <= pnvm_pkg::FUSE_RESET[pnvm_pkg::FUSE_SERIAL_BIT];
            brownout_threshold_fuse <= pnvm_pkg::FUSE_RESET[pnvm_pkg::FUSE_BO_LEVEL_BIT];
            brownout_detect_enable_fuse <= pnvm_pkg::FUSE_RESET[pnvm_pkg::FUSE_BO_DETECT_BIT];
            clock_source_select_fuse <= pnvm_pkg::FUSE_RESET[pnvm_pkg::FUSE_CLK_HI_BIT:0];
        end
        else
        begin
            ready_busy_indicator <= 1'b1;
            serial_program_enable_fuse <= fuse_r[pnvm_pkg::FUSE_SERIAL_BIT];
            brownout_threshold_fuse <= fuse_r[pnvm_pkg::FUSE_BO_LEVEL_BIT];
            brownout_detect_enable_fuse <= fuse_r[pnvm_pkg::FUSE_BO_DETECT_BIT];
            clock_source_select_fuse <= fuse_r[pnvm_pkg::FUSE_CLK_HI_BIT:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_cmd_holds: assert property (@(posedge sys_clk) disable iff (!rstn)
        !(wr_req && op == pnvm_pkg::LOAD_CMD) |=> $stable(cmd_r))
        else $error("command changed without load");
    a_ready_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
        ##1 ready_busy_indicator)
        else $error("busy shown");
    a_lock_never_up: assert property (@(posedge sys_clk) disable iff (!rstn)
        op != pnvm_pkg::CHIP_ERASE |=> (lock_r & ~$past(lock_r)) == 2'h0)
        else $error("lock bit reverted");
    a_fuse_prog: assert property (@(posedge sys_clk) disable iff (!rstn)
        op == pnvm_pkg::WRITE_STEP && cmd_r == pnvm_pkg::CMD_FUSE_WRITE
        |=> fuse_r == $past(data_r[pnvm_pkg::FUSE_HI_BIT:0]))
        else $error("fuse not programmed");
    a_lock_prog: assert property (@(posedge sys_clk) disable iff (!rstn)
        op == pnvm_pkg::WRITE_STEP && cmd_r == pnvm_pkg::CMD_LOCK_WRITE
        |=> lock_r == ($past(lock_r)
        & $past(data_r[pnvm_pkg::LOCK_HI_BIT:pnvm_pkg::LOCK_LO_BIT])))
        else $error("lock not programmed");
    a_fuse_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        !oe_n_r && !bsel_r && cmd_r == pnvm_pkg::CMD_FUSE_READ
        |=> !data_oe_n && data_o == {pnvm_pkg::FUSE_RSVD, $past(fuse_r)})
        else $error("fuse status not driven");
    a_ee_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        !oe_n_r && !bsel_r && cmd_r == pnvm_pkg::CMD_EE_READ
        |=> !data_oe_n && data_o == $past(ee_rdata))
        else $error("eeprom byte not driven");
    a_bus_release: assert property (@(posedge sys_clk) disable iff (!rstn)
        (oe_n_r || bsel_r) |=> data_oe_n && data_o == pnvm_pkg::BUS_IDLE)
        else $error("data bus driven while released");
    a_fuse_pins: assert property (@(posedge sys_clk) disable iff (!rstn)
        ##1 serial_program_enable_fuse == $past(fuse_r[pnvm_pkg::FUSE_SERIAL_BIT])
        && brownout_threshold_fuse == $past(fuse_r[pnvm_pkg::FUSE_BO_LEVEL_BIT])
        && brownout_detect_enable_fuse == $past(fuse_r[pnvm_pkg::FUSE_BO_DETECT_BIT])
        && clock_source_select_fuse == $past(fuse_r[pnvm_pkg::FUSE_CLK_HI_BIT:0]))
        else $error("fuse pins wrong");
    a_ee_write: assert property (@(posedge sys_clk) disable iff (!rstn)
        ee_we ##1 $stable(addr_r) |=> ee_rdata == $past(data_r, 2))
        else $error("eeprom byte not stored");
endmodule : pnvm_top
`default_nettype wire

// ==== verification/pnvm_prog_model.sv ====
// Programmer model that drives the programming link over the register bus
`timescale 1ns/1ps
`default_nettype none
module pnvm_prog_model (
    input wire logic sys_clk,
    output logic [31:0] wb_adr_i,
    output logic [31:0] wb_dat_i,
    output logic [3:0] wb_sel_i,
    output logic wb_we_i,
    output logic wb_cyc_i,
    output logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] data_o,
    input wire logic data_oe_n
);
    initial
    begin
        wb_adr_i = 32'h0;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h0;
        wb_we_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Single classic bus cycle
    task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge sys_clk);
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1) @(posedge sys_clk);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb
    // One programming step: output enable, byte select, op, operand
    task automatic step(input logic oe, input logic bsel, input logic [2:0] op,
        input logic [7:0] v);
        logic [31:0] q;
        wb(pnvm_pkg::WB_ADDR_CTRL, 1'b1, {19'h0, oe, bsel, op, v}, q);
    endtask : step
    ////////////////////////////////////////////////////////////////////////
    // Output enable low with byte select low, sample, then release
    task automatic rd_bus(output logic [7:0] v);
        step(1'b0, 1'b0, 3'h0, 8'h00);
        while (data_oe_n !== 1'b0) @(posedge sys_clk);
        v = data_o;
        step(1'b1, 1'b0, 3'h0, 8'h00);
    endtask : rd_bus
    task automatic ee_write(input logic [7:0] a, input logic [7:0] d);
        step(1'b1, 1'b0, pnvm_pkg::LOAD_CMD, pnvm_pkg::CMD_EE_WRITE);
        step(1'b1, 1'b0, pnvm_pkg::LOAD_ADDR, a);
        step(1'b1, 1'b0, pnvm_pkg::LOAD_DATA, d);
        step(1'b1, 1'b0, pnvm_pkg::WRITE_STEP, 8'h00);
    endtask : ee_write
    // Caller keeps reserved fuse bits 7..6 and lock bits 7..3, 0 at one
    task automatic nv_prog(input logic [7:0] c, input logic [7:0] d);
        step(1'b1, 1'b0, pnvm_pkg::LOAD_CMD, c);
        step(1'b1, 1'b0, pnvm_pkg::LOAD_DATA, d);
        step(1'b1, 1'b0, pnvm_pkg::WRITE_STEP, 8'h00);
    endtask : nv_prog
endmodule : pnvm_prog_model
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking testbench for the parallel programming block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
    logic [3:0] wb_sel_i;
    logic wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, data_oe_n, ready_busy_indicator;
    logic serial_program_enable_fuse, brownout_threshold_fuse, brownout_detect_enable_fuse;
    logic [2:0] clock_source_select_fuse;
    logic [7:0] data_o, v;
    logic [5:0] fuse_pins;
    int err_count = 0;
    int check_count = 0;
    assign fuse_pins = {serial_program_enable_fuse, brownout_threshold_fuse,
        brownout_detect_enable_fuse, clock_source_select_fuse};
    always #20 sys_clk = ~sys_clk;
    pnvm_top #(.AW(7)) dut (.sys_clk, .rstn, .wb_adr_i, .wb_dat_i, .wb_sel_i,
        .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .data_o, .data_oe_n,
        .ready_busy_indicator, .serial_program_enable_fuse, .brownout_threshold_fuse,
        .brownout_detect_enable_fuse, .clock_source_select_fuse);
    pnvm_prog_model prog (.sys_clk, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
        .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .data_o, .data_oe_n);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // Lets registered pins follow the last committed write
    task automatic settle();
        repeat (2) @(negedge sys_clk);
    endtask : settle
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("fuse pins", {26'h0, fuse_pins}, 32'h3F);
        chk("ready", {31'h0, ready_busy_indicator}, 32'h1);
        chk("oe_n", {31'h0, data_oe_n}, 32'h1);
        prog.wb(pnvm_pkg::WB_ADDR_FUSE, 1'b0, 32'h0, q);
        chk("fuse reg", q, 32'h3FF);
        prog.wb(32'h10, 1'b0, 32'h0, q);
        chk("unmapped", q, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_eeprom();
        prog.ee_write(8'h05, 8'hA5);
        prog.step(1'b1, 1'b0, pnvm_pkg::LOAD_ADDR, 8'h7F);
        prog.step(1'b1, 1'b0, pnvm_pkg::LOAD_DATA, 8'h5A);
        prog.step(1'b1, 1'b0, pnvm_pkg::WRITE_STEP, 8'h00);
        prog.wb(pnvm_pkg::WB_ADDR_STAT, 1'b0, 32'h0, q);
        chk("data latch", q, 32'h5A);
        prog.step(1'b1, 1'b0, pnvm_pkg::LOAD_CMD, pnvm_pkg::CMD_EE_READ);
        prog.wb(pnvm_pkg::WB_ADDR_CTRL, 1'b0, 32'h0, q);
        chk("ctrl reg", q, 32'h1003);
        prog.step(1'b1, 1'b0, pnvm_pkg::LOAD_ADDR, 8'h05);
        prog.rd_bus(v);
        chk("ee 05", {24'h0, v}, 32'hA5);
        prog.step(1'b1, 1'b0, pnvm_pkg::LOAD_ADDR, 8'h7F);
        prog.rd_bus(v);
        chk("ee 7F", {24'h0, v}, 32'h5A);
        prog.step(1'b0, 1'b1, 3'h0, 8'h00);
        repeat (3) @(negedge sys_clk);
        chk("bsel oe_n", {31'h0, data_oe_n}, 32'h1);
        chk("bsel data", {24'h0, data_o}, 32'h0);
        prog.step(1'b1, 1'b0, 3'h0, 8'h00);
        $display("eeprom test done");
    endtask : t_eeprom
    task automatic t_fuse();
        prog.nv_prog(pnvm_pkg::CMD_FUSE_WRITE, 8'hD5);
        settle();
        chk("fuse pins", {26'h0, fuse_pins}, 32'h15);
        chk("ready", {31'h0, ready_busy_indicator}, 32'h1);
        prog.step(1'b1, 1'b0, pnvm_pkg::LOAD_CMD, pnvm_pkg::CMD_FUSE_READ);
        prog.rd_bus(v);
        chk("fuse bus", {24'h0, v}, 32'hD5);
        prog.nv_prog(pnvm_pkg::CMD_FUSE_WRITE, 8'hFF);
        settle();
        chk("fuse erased", {26'h0, fuse_pins}, 32'h3F);
        $display("fuse test done");
    endtask : t_fuse
    task automatic t_lock();
        prog.nv_prog(pnvm_pkg::CMD_LOCK_WRITE, 8'hFD);
        prog.wb(pnvm_pkg::WB_ADDR_FUSE, 1'b0, 32'h0, q);
        chk("lock 1", q, 32'h2FF);
        prog.nv_prog(pnvm_pkg::CMD_LOCK_WRITE, 8'hFB);
        prog.nv_prog(pnvm_pkg::CMD_LOCK_WRITE, 8'hFF);
        prog.wb(pnvm_pkg::WB_ADDR_FUSE, 1'b0, 32'h0, q);
        chk("lock kept", q, 32'h0FF);
        prog.step(1'b1, 1'b0, pnvm_pkg::CHIP_ERASE, 8'h00);
        prog.wb(pnvm_pkg::WB_ADDR_FUSE, 1'b0, 32'h0, q);
        chk("lock erased", q, 32'h3FF);
        $display("lock test done");
    endtask : t_lock
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset();
        t_eeprom();
        t_fuse();
        t_lock();
        print_verdict();
    end
    initial
    begin
        #400000;
        err_count++;
        print_verdict();
    end
endmodule : tb
`default_nettype wire
